// ---- rtl/iaps_sequencer.sv ----
`timescale 1ns/100ps
// Overview of operation
// - successful unlock sets the enabled flag; only then operations take effect
// - erase and buffer write run only after unlock
// - erase tagging: each high data write advances address, saturates at 11111b
// - only tagged words are erased
// - erased words read back as 0000h
// - trigger bit starts the key window timer
// - key bytes 00 0d c3 04 09 40 go into key registers
// - trigger bit clears itself when the timer expires
// - wrong key leaves erase and write disabled
// - clearing the enabled flag disables at once
// - buffer holds 32 sixteen bit words, one page
// - page chosen by address bits 11 to 5
// - buffer address advances per high write, holds at last word
// - write mode start moves buffer into the page; bit high till done
// - processor halts while erase or write runs
// - start bit high time follows the time select bit
// - select 0: 3.2/2.2 ms, select 1: 3.7/3.0 ms
// - low write stores only; high write loads word and increments
// - hardware clears start bit when done
module iaps_sequencer #(
  parameter int ERASE0 = iaps_pkg::ERASE0_CYC,
  parameter int WRITE0 = iaps_pkg::WRITE0_CYC,
  parameter int ERASE1 = iaps_pkg::ERASE1_CYC,
  parameter int WRITE1 = iaps_pkg::WRITE1_CYC,
  parameter int KEY_WIN = iaps_pkg::KEY_WIN_CYC
) (
  // clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // flash array port
  output logic O_FL_ERASE,
  output logic O_FL_WRITE,
  output logic [11:0] O_FL_ADDR,
  output logic [15:0] O_FL_WDATA,
  // processor
  output logic O_CPU_HALT
);
  initial
  begin
    // an op shorter than one page walk would wrap op_len minus 32
    if (ERASE0 < 33 || WRITE0 < 33 || ERASE1 < 33 || WRITE1 < 33 || KEY_WIN < 1)
      $error("iaps_sequencer: op counts must exceed one page walk");
    if (ERASE1 >= 2**20 || ERASE0 >= 2**20 || WRITE0 >= 2**20 || WRITE1 >= 2**20 ||
        KEY_WIN >= 2**20)
      $error("iaps_sequencer: count too wide");
  end

  // =====================================================================
  // registers
  logic [2:0] op_mode_sel;
  logic unlock_trigger, erase_write_enabled, write_initiate;
  logic buffer_clear, program_time_sel;
  logic [7:0] flash_addr_lo;
  logic [3:0] flash_addr_hi;
  logic [7:0] data_word0_lo, data_word0_hi;
  logic [7:0] key_word1_lo, key_word1_hi, key_word2_lo, key_word2_hi;
  logic [7:0] key_word3_lo, key_word3_hi;
  logic [15:0] wbuf [iaps_pkg::PAGE_WORDS];
  logic [31:0] tag;
  logic [19:0] key_cnt, op_cnt;
  logic [4:0] walk;
  iaps_pkg::iaps_state_e state;

  // =====================================================================
  // bus decode
  wire wr = I_CE && I_PSEL && I_PENABLE && I_PWRITE;
  wire wr_c0 = wr && I_PADDR == iaps_pkg::OFS_CTRL0;
  wire wr_c2 = wr && I_PADDR == iaps_pkg::OFS_CTRL2;
  wire wr_d0h = wr && I_PADDR == iaps_pkg::OFS_D0_HI;
  wire [11:0] addr = {flash_addr_hi, flash_addr_lo};
  wire [4:0] off = addr[4:0];
  wire busy = state == iaps_pkg::ST_BUSY;
  wire key_ok = key_word1_lo == iaps_pkg::KEY1_LO && key_word2_lo == iaps_pkg::KEY2_LO &&
    key_word3_lo == iaps_pkg::KEY3_LO && key_word1_hi == iaps_pkg::KEY1_HI &&
    key_word2_hi == iaps_pkg::KEY2_HI && key_word3_hi == iaps_pkg::KEY3_HI;
  wire start_req = wr_c0 && I_PWDATA[iaps_pkg::CTRL0_INIT_BIT] && !busy;
  wire mode_ok = op_mode_sel == iaps_pkg::MODE_WRITE || op_mode_sel == iaps_pkg::MODE_ERASE;
  wire start_ok = start_req && erase_write_enabled && mode_ok;
  wire is_erase = op_mode_sel == iaps_pkg::MODE_ERASE;
  wire [19:0] op_len = is_erase ? (program_time_sel ? 20'(ERASE1) : 20'(ERASE0))
    : (program_time_sel ? 20'(WRITE1) : 20'(WRITE0));
  wire op_done = busy && op_cnt == 20'h00001;
  wire [7:0] c0_rd = {erase_write_enabled, op_mode_sel, unlock_trigger, write_initiate, 2'h0};

  function automatic logic [7:0] rd_sel(input logic [7:0] a);
    case (a)
      iaps_pkg::OFS_CTRL0: rd_sel = c0_rd;
      iaps_pkg::OFS_CTRL2: rd_sel = {6'h00, program_time_sel, buffer_clear};
      iaps_pkg::OFS_ADDR_LO: rd_sel = flash_addr_lo;
      iaps_pkg::OFS_ADDR_HI: rd_sel = {4'h0, flash_addr_hi};
      iaps_pkg::OFS_D0_LO: rd_sel = data_word0_lo;
      iaps_pkg::OFS_D0_HI: rd_sel = data_word0_hi;
      iaps_pkg::OFS_K1_LO: rd_sel = key_word1_lo;
      iaps_pkg::OFS_K1_HI: rd_sel = key_word1_hi;
      iaps_pkg::OFS_K2_LO: rd_sel = key_word2_lo;
      iaps_pkg::OFS_K2_HI: rd_sel = key_word2_hi;
      iaps_pkg::OFS_K3_LO: rd_sel = key_word3_lo;
      iaps_pkg::OFS_K3_HI: rd_sel = key_word3_hi;
      default: rd_sel = 8'h00;
    endcase
  endfunction

  // apb answers in the first access cycle; unmapped reads give zero
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = 1'b0;
  assign O_CPU_HALT = busy;

  always_ff @(posedge I_CLK)
    if (I_RST)
      O_PRDATA <= 32'h0;
    else if (I_CE && I_PSEL && !I_PENABLE)
      O_PRDATA <= {24'h0, rd_sel(I_PADDR)};

  // =====================================================================
  // control register 0
  always_ff @(posedge I_CLK)
    if (I_RST)
    begin
      op_mode_sel <= iaps_pkg::MODE_WRITE;
      unlock_trigger <= 1'b0;
      erase_write_enabled <= 1'b0;
      key_cnt <= 20'h0;
    end
    else if (I_CE)
    begin
      if (wr_c0)
        op_mode_sel <= I_PWDATA[iaps_pkg::CTRL0_MODE_LSB +: 3];
      if (unlock_trigger && key_cnt == 20'h1)
      begin
        unlock_trigger <= 1'b0;
        erase_write_enabled <= key_ok;
      end
      else if (wr_c0 && !I_PWDATA[iaps_pkg::CTRL0_EN_BIT])
        erase_write_enabled <= 1'b0;
      if (wr_c0 && I_PWDATA[iaps_pkg::CTRL0_TRIG_BIT] && !unlock_trigger &&
          I_PWDATA[iaps_pkg::CTRL0_MODE_LSB +: 3] == iaps_pkg::MODE_UNLOCK)
      begin
        unlock_trigger <= 1'b1;
        key_cnt <= 20'(KEY_WIN);
      end
      else if (key_cnt != 20'h0)
        key_cnt <= key_cnt - 20'h1;
    end

  // =====================================================================
  // key and data registers
  always_ff @(posedge I_CLK)
    if (I_RST)
    begin
      {key_word1_lo, key_word1_hi, key_word2_lo, key_word2_hi} <= 32'h0;
      {key_word3_lo, key_word3_hi, data_word0_lo, data_word0_hi} <= 32'h0;
      {program_time_sel, flash_addr_hi, flash_addr_lo} <= 13'h0;
    end
    else if (wr)
    begin
      case (I_PADDR)
        iaps_pkg::OFS_K1_LO: key_word1_lo <= I_PWDATA[7:0];
        iaps_pkg::OFS_K1_HI: key_word1_hi <= I_PWDATA[7:0];
        iaps_pkg::OFS_K2_LO: key_word2_lo <= I_PWDATA[7:0];
        iaps_pkg::OFS_K2_HI: key_word2_hi <= I_PWDATA[7:0];
        iaps_pkg::OFS_K3_LO: key_word3_lo <= I_PWDATA[7:0];
        iaps_pkg::OFS_K3_HI: key_word3_hi <= I_PWDATA[7:0];
        iaps_pkg::OFS_D0_LO: data_word0_lo <= I_PWDATA[7:0];
        iaps_pkg::OFS_D0_HI: data_word0_hi <= I_PWDATA[7:0];
        iaps_pkg::OFS_ADDR_LO: flash_addr_lo <= I_PWDATA[7:0];
        iaps_pkg::OFS_ADDR_HI: flash_addr_hi <= I_PWDATA[3:0];
        iaps_pkg::OFS_CTRL2: program_time_sel <= I_PWDATA[iaps_pkg::CTRL2_TSEL_BIT];
        default: ;
      endcase
      if (wr_d0h && off != 5'h1f)
        flash_addr_lo <= flash_addr_lo + 8'h01;
    end

  // =====================================================================
  // write buffer and erase tags
  always_ff @(posedge I_CLK)
    if (I_RST)
    begin
      tag <= 32'h0;
      buffer_clear <= 1'b0;
    end
    else if (I_CE)
    begin
      // clearing takes one cycle; the bit reads high until it completes
      buffer_clear <= wr_c2 && I_PWDATA[iaps_pkg::CTRL2_CLR_BIT] && !busy;
      if (buffer_clear)
        tag <= 32'h0;
      else if (wr_d0h)
        tag[off] <= 1'b1;
    end

  always_ff @(posedge I_CLK)
    if (I_CE && buffer_clear)
      for (int i = 0; i < iaps_pkg::PAGE_WORDS; i++)
        wbuf[i] <= 16'h0;
    else if (I_CE && wr_d0h)
      wbuf[off] <= {I_PWDATA[7:0], data_word0_lo};

  // =====================================================================
  // operation sequencer: walks the page once, then waits out the time
  always_ff @(posedge I_CLK)
    if (I_RST)
    begin
      state <= iaps_pkg::ST_IDLE;
      write_initiate <= 1'b0;
      op_cnt <= 20'h0;
      walk <= 5'h0;
    end
    else if (I_CE)
    begin
      unique case (state)
        iaps_pkg::ST_IDLE:
          if (start_ok)
          begin
            state <= iaps_pkg::ST_BUSY;
            write_initiate <= 1'b1;
            op_cnt <= op_len;
            walk <= 5'h0;
          end
        iaps_pkg::ST_BUSY:
        begin
          op_cnt <= op_cnt - 20'h1;
          if (walk != 5'h1f)
            walk <= walk + 5'h1;
          if (op_done)
          begin
            state <= iaps_pkg::ST_IDLE;
            write_initiate <= 1'b0;
          end
        end
      endcase
    end

  // page from address bits 11..5, word from walk index
  wire walk_act = busy && op_cnt > op_len - 20'd32;
  always_ff @(posedge I_CLK)
    if (I_RST)
    begin
      O_FL_ERASE <= 1'b0;
      O_FL_WRITE <= 1'b0;
      O_FL_ADDR <= 12'h0;
      O_FL_WDATA <= 16'h0;
    end
    else if (I_CE)
    begin
      O_FL_ADDR <= {addr[11:5], walk};
      O_FL_ERASE <= walk_act && is_erase && tag[walk];
      O_FL_WRITE <= walk_act && !is_erase;
      O_FL_WDATA <= is_erase ? 16'h0000 : wbuf[walk];
    end

  // =====================================================================
  // checks
  halt_busy_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_CPU_HALT == write_initiate) else $error("halt not tied to busy");
  start_gate_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && start_req && !erase_write_enabled |=> !write_initiate)
    else $error("start taken while disabled");
  trig_expire_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && unlock_trigger && key_cnt == 20'h1 |=> !unlock_trigger)
    else $error("trigger did not expire");
  bad_key_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && unlock_trigger && key_cnt == 20'h1 && !key_ok |=> !erase_write_enabled)
    else $error("enabled with bad key");
  good_key_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && unlock_trigger && key_cnt == 20'h1 && key_ok |=> erase_write_enabled)
    else $error("not enabled with good key");
  dis_now_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_c0 && !I_PWDATA[iaps_pkg::CTRL0_EN_BIT] && !(unlock_trigger && key_cnt == 20'h1)
    |=> !erase_write_enabled) else $error("disable late");
  addr_sat_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_d0h && off == 5'h1f |=> flash_addr_lo == $past(flash_addr_lo))
    else $error("address passed page end");
  addr_inc_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wr_d0h && off != 5'h1f |=> flash_addr_lo == $past(flash_addr_lo) + 8'h01)
    else $error("address not advanced");
  busy_len_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && start_ok |=> write_initiate && op_cnt == $past(op_len))
    else $error("wrong busy length");
  done_clr_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    I_CE && op_done |=> !write_initiate) else $error("start bit stuck");
  erase_zero_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    O_FL_ERASE |-> O_FL_WDATA == 16'h0000) else $error("erase not zero");

  unlock_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    !erase_write_enabled ##1 erase_write_enabled);
  erase_c: cover property (@(posedge I_CLK) disable iff (I_RST) O_FL_ERASE);
  write_c: cover property (@(posedge I_CLK) disable iff (I_RST) O_FL_WRITE);
  ignored_c: cover property (@(posedge I_CLK) disable iff (I_RST)
    start_req && !erase_write_enabled);
endmodule

// ---- common/iaps_pkg.sv ----
package iaps_pkg;
  // =====================================================================
  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI = 8'h0c;
  localparam logic [7:0] OFS_D0_LO = 8'h10;
  localparam logic [7:0] OFS_D0_HI = 8'h14;
  localparam logic [7:0] OFS_K1_LO = 8'h18;
  localparam logic [7:0] OFS_K1_HI = 8'h1c;
  localparam logic [7:0] OFS_K2_LO = 8'h20;
  localparam logic [7:0] OFS_K2_HI = 8'h24;
  localparam logic [7:0] OFS_K3_LO = 8'h28;
  localparam logic [7:0] OFS_K3_HI = 8'h2c;
  // =====================================================================
  // ctrl0 and ctrl2 field positions
  localparam int CTRL0_MODE_LSB = 4;
  localparam int CTRL0_TRIG_BIT = 3;
  localparam int CTRL0_INIT_BIT = 2;
  localparam int CTRL0_EN_BIT = 7;
  localparam int CTRL2_CLR_BIT = 0;
  localparam int CTRL2_TSEL_BIT = 1;
  // =====================================================================
  // mode codes
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  // =====================================================================
  // key pattern
  localparam logic [7:0] KEY1_LO = 8'h00;
  localparam logic [7:0] KEY2_LO = 8'h0d;
  localparam logic [7:0] KEY3_LO = 8'hc3;
  localparam logic [7:0] KEY1_HI = 8'h04;
  localparam logic [7:0] KEY2_HI = 8'h09;
  localparam logic [7:0] KEY3_HI = 8'h40;
  // =====================================================================
  // timing, clock period in ns
  localparam int CLK_NS = 10;
  localparam int ERASE0_US = 3200;
  localparam int WRITE0_US = 2200;
  localparam int ERASE1_US = 3700;
  localparam int WRITE1_US = 3000;
  localparam int ERASE0_CYC = ERASE0_US * 1000 / CLK_NS;
  localparam int WRITE0_CYC = WRITE0_US * 1000 / CLK_NS;
  localparam int ERASE1_CYC = ERASE1_US * 1000 / CLK_NS;
  localparam int WRITE1_CYC = WRITE1_US * 1000 / CLK_NS;
  localparam int KEY_WIN_CYC = 1024;
  localparam int PAGE_WORDS = 32;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} iaps_state_e;
endpackage

// ---- test/iap_flash_erase_write_sequencer_tb_top.sv ----
`timescale 1ns/100ps
module iap_flash_erase_write_sequencer_tb_top;
  // ==================================================================
  // short op lengths keep the run brief
  localparam int E0 = 40;
  localparam int W0 = 50;
  localparam int E1 = 60;
  localparam int W1 = 70;
  localparam int KW = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'hfe83;
  logic [31:0] prdata;
  logic pready, pslverr, fl_erase, fl_write, halt;
  logic [11:0] fl_addr;
  logic [15:0] fl_wdata;
  logic [31:0] fl_q[$];
  logic [31:0] rd_q[$];
  logic [15:0] words[33];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int halt_cnt = 0;

  iaps_sequencer #(.ERASE0(E0), .WRITE0(W0), .ERASE1(E1), .WRITE1(W1), .KEY_WIN(KW)) i_dut (
    .I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .O_FL_ERASE(fl_erase), .O_FL_WRITE(fl_write),
    .O_FL_ADDR(fl_addr), .O_FL_WDATA(fl_wdata), .O_CPU_HALT(halt));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ==================================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle cycle after it keeps psel from toggling twice in a step
  // only the bench timeout ends a wait that never sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back({24'h0, exp});
    apb(1'b0, a, 32'h0);
  endtask

  // halt is sampled on the falling edge, clear of the flops' updates
  task automatic op_run(input int len);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while ((halt_cnt == 0 || halt === 1'b1) && n < 700);
    @(posedge clk);
    chk(halt_cnt, len);
  endtask

  task automatic unlock(input logic [7:0] last, input logic [7:0] exp);
    wr(iaps_pkg::OFS_CTRL0, 8'h68);
    rd(iaps_pkg::OFS_CTRL0, 8'h68);
    wr(iaps_pkg::OFS_K1_LO, iaps_pkg::KEY1_LO);
    wr(iaps_pkg::OFS_K2_LO, iaps_pkg::KEY2_LO);
    wr(iaps_pkg::OFS_K3_LO, iaps_pkg::KEY3_LO);
    wr(iaps_pkg::OFS_K1_HI, iaps_pkg::KEY1_HI);
    wr(iaps_pkg::OFS_K2_HI, iaps_pkg::KEY2_HI);
    wr(iaps_pkg::OFS_K3_HI, last);
    repeat (KW) @(posedge clk);
    rd(iaps_pkg::OFS_CTRL0, exp);
  endtask

  // ==================================================================
  // result watcher: pops the oldest note whenever a result shows
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      give_verdict();
    end
    else
    begin
      if (psel && penable && !pwrite && pready === 1'b1 && rd_q.size() > 0)
        chk(prdata, rd_q.pop_front());
      if (fl_erase === 1'b1 || fl_write === 1'b1)
      begin
        if (fl_q.size() > 0)
          chk({fl_erase, fl_write, fl_addr, fl_wdata}, fl_q.pop_front());
        else
          chk({fl_erase, fl_write, fl_addr, fl_wdata}, 32'hffffffff);
      end
    end
  end

  always @(negedge clk)
  begin
    if (halt === 1'b1)
      halt_cnt++;
  end

  // ==================================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'h14);
    repeat (10) @(posedge clk);
    chk(halt_cnt, 0);
    unlock(8'h41, 8'h60);
    unlock(iaps_pkg::KEY3_HI, 8'he0);
    // erase: five tags from index 1c saturate at 1f, four words erased
    wr(iaps_pkg::OFS_CTRL0, 8'h90);
    wr(iaps_pkg::OFS_CTRL2, 8'h01);
    wr(iaps_pkg::OFS_ADDR_LO, 8'h3c);
    wr(iaps_pkg::OFS_ADDR_HI, 8'h05);
    for (int i = 0; i < 5; i++)
    begin
      seed = xs(seed);
      wr(iaps_pkg::OFS_D0_HI, seed[7:0]);
    end
    rd(iaps_pkg::OFS_ADDR_LO, 8'h3f);
    for (int i = 0; i < 4; i++)
      fl_q.push_back({4'h2, 12'h53c + 12'(i), 16'h0000});
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'h94);
    op_run(E0);
    rd(iaps_pkg::OFS_CTRL0, 8'h90);
    // full page write into the page erased above, 33rd word lands on the held last index
    wr(iaps_pkg::OFS_CTRL0, 8'h80);
    wr(iaps_pkg::OFS_CTRL2, 8'h03);
    wr(iaps_pkg::OFS_ADDR_LO, 8'h20);
    for (int i = 0; i < 33; i++)
    begin
      seed = xs(seed);
      words[i] = seed[15:0];
      wr(iaps_pkg::OFS_D0_LO, words[i][7:0]);
      wr(iaps_pkg::OFS_D0_HI, words[i][15:8]);
    end
    for (int i = 0; i < 32; i++)
      fl_q.push_back({4'h1, 12'h520 + 12'(i), (i == 31) ? words[32] : words[i]});
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'h84);
    op_run(W1);
    // rewrite one word without erasing, short time select
    wr(iaps_pkg::OFS_CTRL2, 8'h01);
    wr(iaps_pkg::OFS_ADDR_LO, 8'h25);
    wr(iaps_pkg::OFS_D0_LO, 8'ha5);
    rd(iaps_pkg::OFS_ADDR_LO, 8'h25);
    wr(iaps_pkg::OFS_D0_HI, 8'h5a);
    // the whole cleared buffer goes out; only word 5 carries data
    for (int i = 0; i < 32; i++)
      fl_q.push_back({4'h1, 12'h520 + 12'(i), (i == 5) ? 16'h5aa5 : 16'h0000});
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'h84);
    // freeze five cycles after the page walk; the halt stretches by as many
    repeat (40) @(posedge clk);
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    op_run(W0 + 5);
    // a start in a mode that is neither write nor erase is ignored
    wr(iaps_pkg::OFS_CTRL0, 8'hb0);
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'hb4);
    repeat (10) @(posedge clk);
    chk(halt_cnt, 0);
    // disable directly, then a start must be ignored
    wr(iaps_pkg::OFS_CTRL0, 8'h00);
    rd(iaps_pkg::OFS_CTRL0, 8'h00);
    halt_cnt = 0;
    wr(iaps_pkg::OFS_CTRL0, 8'h14);
    repeat (10) @(posedge clk);
    chk(halt_cnt, 0);
    chk(fl_q.size(), 0);
    give_verdict();
  end
endmodule
